// ===== design/ifeb_bank.sv
// Interrupt flag and enable bank with an AXI4-Lite register slave.
// Assumes event and pin inputs synchronous to aclk, one write and one
// read under way at a time.
// Contract
// - Pin 1 edge select at bits 3:2: off, rising, falling, both.
// - Pin 0 edge select at bits 1:0 with the same encoding.
// - Upper four bits of the edge select register read zero.
// - Top bit of primary control 0 reads zero.
// - Global interrupt enable sits at bit 0 of primary control 0.
// - Flags: 1 pending, 0 none; enables: 1 enabled, 0 disabled.
// - Control 0: usb flag 6, pin1 flag 5, pin0 flag 4, enables 3..1.
// - Control 1: group 1, group 0, comparator 1, 0 flags, then enables.
// - Control 2: serial, groups 4, 3, 2 flags, then matching enables.
// - Control 3: group 5, time bases 1, 0, spi-a flags, then enables.
// - Group 5: eeprom, adc, uart, low voltage flags, then enables.
// - Groups 0-3: compare A flag 5, P flag 4, enables 1 and 0.
// - Four primary, six group and one edge register in the map.
// - Every source has its own enable and, except global, a flag.
// - Events set sticky flags; a request needs the matching enable.
// - Global enable cleared suppresses every interrupt.
module ifeb_bank
    import ifeb_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ext_pin_0,
    input wire logic ext_pin_1,
    input wire ifeb_evt_t src_evt,
    input wire logic [NUM_GRP-1:0][3:0] grp_evt,
    output logic [NUM_SRC-1:0] cpu_req,
    output logic global_irq_en,
    output logic irq
);

    ifeb_wr_state_t wr_state;
    logic [ADDR_W-1:0] addr_q;
    logic [31:0] data_q;
    logic [3:0] strb_q;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic [4:0] wr_dec;
    logic [4:0] rd_dec;
    logic [IDX_LAST:0] reg_we;
    logic [7:0] edge_sel;
    logic [7:0] prim [NUM_PRIM];
    logic [7:0] prim_set [NUM_PRIM];
    logic [7:0] grp [NUM_GRP];
    logic [NUM_GRP-1:0] grp_act;
    logic [NUM_SRC-1:0] pf;
    logic [NUM_SRC-1:0] pe;
    logic [NUM_SRC-1:0] src_set;
    logic [NUM_SRC-1:0] irq_status;
    logic [NUM_SRC-1:0] irq_mask;
    logic pin0_prev;
    logic pin1_prev;
    logic pin_armed;
    logic pin0_hit;
    logic pin1_hit;
    logic [31:0] next_rdata;

    // Address decode: bit 4 marks a mapped word, bits 3:0 its index
    function automatic logic [4:0] reg_index(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = (a[ADDR_W-1:2] <= (ADDR_W-2)'(IDX_LAST));
        reg_index = {hit, a[5:2]};
    endfunction

    // Edge detector shared by both pins
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic cur,
                                      input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (sel)
            EDGE_RISE: edge_hit = rise;
            EDGE_FALL: edge_hit = fall;
            EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    // Writable bits of each group register
    function automatic logic [7:0] grp_mask(input int g);
        grp_mask = (g == NUM_GRP - 1) ? GRP_FULL_MASK : GRP_TIMER_MASK;
    endfunction

    // Write channel handshake; address and data may come in either order
    assign awready = (wr_state == WR_IDLE) || (wr_state == WR_DATA);
    assign wready = (wr_state == WR_IDLE) || (wr_state == WR_ADDR);
    assign wr_fire = (wr_state == WR_IDLE && awvalid && wvalid) ||
                     (wr_state == WR_ADDR && wvalid) ||
                     (wr_state == WR_DATA && awvalid);
    assign wr_addr = (wr_state == WR_ADDR) ? addr_q : awaddr;
    assign wr_data = (wr_state == WR_DATA) ? data_q : wdata;
    assign wr_strb = (wr_state == WR_DATA) ? strb_q : wstrb;
    assign wr_dec = reg_index(wr_addr);
    assign rd_dec = reg_index(araddr);

    // Write state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state <= WR_IDLE;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state <= WR_RESP;
                    end else if (awvalid) begin
                        wr_state <= WR_ADDR;
                    end else if (wvalid) begin
                        wr_state <= WR_DATA;
                    end
                end
                WR_ADDR: begin
                    if (wvalid) begin
                        wr_state <= WR_RESP;
                    end
                end
                WR_DATA: begin
                    if (awvalid) begin
                        wr_state <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        wr_state <= WR_IDLE;
                    end
                end
                default: wr_state <= WR_IDLE;
            endcase
        end
    end

    // Hold whichever half of a write arrived first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= '0;
            data_q <= 32'h0000_0000;
            strb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                data_q <= wdata;
                strb_q <= wstrb;
            end
        end
    end

    // Write response; unmapped words answer with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= wr_dec[4] ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Per-register write enables, byte lane 0 only for 8-bit words
    always_comb begin
        reg_we = '0;
        if (wr_fire && wr_dec[4] && wr_strb[0]) begin
            reg_we[wr_dec[3:0]] = 1'b1;
        end
    end

    // Pin history; arming avoids a false edge right after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin0_prev <= 1'b0;
            pin1_prev <= 1'b0;
            pin_armed <= 1'b0;
        end else begin
            pin0_prev <= ext_pin_0;
            pin1_prev <= ext_pin_1;
            pin_armed <= 1'b1;
        end
    end

    assign pin1_hit = pin_armed &&
        edge_hit(edge_sel[EDGE_PIN1_LSB+:2], ext_pin_1, pin1_prev);
    assign pin0_hit = pin_armed &&
        edge_hit(edge_sel[EDGE_PIN0_LSB+:2], ext_pin_0, pin0_prev);

    // Edge select register; upper nibble is not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_sel <= REG_RESET;
        end else if (reg_we[IDX_EDGE]) begin
            edge_sel <= wr_data[7:0] & EDGE_MASK;
        end
    end

    // Group activity feeds the primary group flags
    always_comb begin
        for (int g = 0; g < NUM_GRP; g++) begin
            grp_act[g] = |(grp[g][7:4] & grp[g][3:0]);
        end
    end

    // Flag set terms at their bit positions, upper nibbles only
    assign prim_set[0] = {1'b0, src_evt.usb, pin1_hit, pin0_hit,
                          4'h0};
    assign prim_set[1] = {grp_act[1], grp_act[0], src_evt.cp1,
                          src_evt.cp0, 4'h0};
    assign prim_set[2] = {src_evt.sim, grp_act[4], grp_act[3],
                          grp_act[2], 4'h0};
    assign prim_set[3] = {grp_act[5], src_evt.tb1, src_evt.tb0,
                          src_evt.spia, 4'h0};

    // Primary registers; a set in the write cycle wins over the clear
    for (genvar r = 0; r < NUM_PRIM; r++) begin : g_prim
        localparam logic [7:0] WMASK = (r == 0) ? PRIM0_MASK : PRIM_MASK;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                prim[r] <= REG_RESET;
            end else if (reg_we[IDX_PRIM0 + 4'(r)]) begin
                prim[r] <= (wr_data[7:0] & WMASK) | prim_set[r];
            end else begin
                prim[r] <= prim[r] | prim_set[r];
            end
        end
    end

    // Group registers; timer groups and group 4 keep only bits 5,4,1,0
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        logic [7:0] gset;
        assign gset = {grp_evt[g], 4'h0} & grp_mask(g);
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                grp[g] <= REG_RESET;
            end else if (reg_we[IDX_GRP0 + 4'(g)]) begin
                grp[g] <= (wr_data[7:0] & grp_mask(g)) | gset;
            end else begin
                grp[g] <= grp[g] | gset;
            end
        end
    end

    // Flattened primary flags and enables, same order in both
    assign pf = {prim[3][7:4], prim[2][7:4], prim[1][7:4],
                 prim[0][6:4]};
    assign pe = {prim[3][3:0], prim[2][3:0], prim[1][3:0], prim[0][3:1]};
    assign src_set = {prim_set[3][7:4], prim_set[2][7:4],
                      prim_set[1][7:4], prim_set[0][6:4]};
    assign global_irq_en = prim[0][GLOBAL_EN_BIT];

    // Requests to the core need flag, enable and the global enable
    assign cpu_req = pf & pe & {NUM_SRC{global_irq_en}};

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= SRC_RESET;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (src_set[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_fire && wr_dec[4] &&
                             wr_dec[3:0] == IDX_STATUS &&
                             wr_strb[i / 8] && wr_data[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt mask, two byte lanes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= SRC_RESET;
        end else if (wr_fire && wr_dec[4] && wr_dec[3:0] == IDX_MASK) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (wr_strb[i / 8]) begin
                    irq_mask[i] <= wr_data[i];
                end
            end
        end
    end

    // Level interrupt, also held off by the global enable
    assign irq = global_irq_en && |(irq_status & irq_mask);

    // Read mux; unimplemented bits are zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (rd_dec[3:0])
            IDX_EDGE: next_rdata[7:0] = edge_sel;
            IDX_STATUS: next_rdata[NUM_SRC-1:0] = irq_status;
            IDX_MASK: next_rdata[NUM_SRC-1:0] = irq_mask;
            default: begin
                if (rd_dec[3:0] >= IDX_PRIM0 && rd_dec[3:0] < IDX_GRP0) begin
                    next_rdata[7:0] = prim[2'(rd_dec[3:0] - IDX_PRIM0)];
                end else if (rd_dec[4]) begin
                    next_rdata[7:0] = grp[3'(rd_dec[3:0] - IDX_GRP0)];
                end
            end
        endcase
        if (!rd_dec[4]) begin
            next_rdata = 32'h0000_0000;
        end
    end

    // Read channel, one cycle after the address is taken
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rd_dec[4] ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Checks
    chk_pin1_rise_set: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_armed && edge_sel[3:2] == EDGE_RISE && ext_pin_1 && !pin1_prev
        |=> pf[SRC_PIN1])
        else $error("pin 1 rising edge did not set its flag");
    chk_pin0_fall_set: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_armed && edge_sel[1:0] == EDGE_FALL && !ext_pin_0 && pin0_prev
        |=> pf[SRC_PIN0])
        else $error("pin 0 falling edge did not set its flag");
    chk_edge_upper_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        arvalid && arready && rd_dec == {1'b1, IDX_EDGE}
        |=> rvalid && rdata[31:4] == 28'h0)
        else $error("edge select upper bits read nonzero");
    chk_ctrl0_top_zero: assert property (@(posedge aclk)
        disable iff (!aresetn)
        arvalid && arready && rd_dec == {1'b1, IDX_PRIM0}
        |=> rdata[31:7] == 25'h0)
        else $error("primary control 0 bit 7 read nonzero");
    chk_global_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !prim[0][0] |-> !irq && cpu_req == '0)
        else $error("interrupt seen with global enable clear");
    chk_req_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_req[SRC_USB] == (prim[0][6] && prim[0][3] && prim[0][0]) &&
        cpu_req[SRC_PIN0] == (prim[0][4] && prim[0][1] && prim[0][0]))
        else $error("request does not follow flag and enable");
    chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        pf[SRC_USB] && !reg_we[IDX_PRIM0] |=> pf[SRC_USB])
        else $error("usb flag dropped without a write");
    chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
        src_evt.usb && reg_we[IDX_PRIM0] |=> pf[SRC_USB])
        else $error("usb event lost under a clearing write");
    chk_group_raise: assert property (@(posedge aclk) disable iff (!aresetn)
        grp[0][5] && grp[0][1] |=> pf[SRC_MF0])
        else $error("group 0 activity did not raise its flag");
    chk_group_unused: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (grp[4] & ~GRP_TIMER_MASK) == 8'h00 &&
        (grp[0] & ~GRP_TIMER_MASK) == 8'h00)
        else $error("unimplemented group bits set");
    chk_write_answer: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire |=> bvalid && (bresp == RESP_OKAY) == $past(wr_dec[4]))
        else $error("write response missing or wrong");

endmodule

// ===== design/ifeb_pkg.sv
// Shared constants and types of the interrupt flag and enable bank.
// Assumes a single aclk domain; register offsets are word aligned.
package ifeb_pkg;

    // Register word indices; byte offset is four times the index
    localparam logic [3:0] IDX_EDGE = 4'h0;
    localparam logic [3:0] IDX_PRIM0 = 4'h1;
    localparam logic [3:0] IDX_GRP0 = 4'h5;
    localparam logic [3:0] IDX_STATUS = 4'hB;
    localparam logic [3:0] IDX_MASK = 4'hC;
    localparam logic [3:0] IDX_LAST = 4'hC;

    // Counts of registers and primary sources
    localparam int NUM_PRIM = 4;
    localparam int NUM_GRP = 6;
    localparam int NUM_SRC = 15;

    // Edge select field positions and the global enable bit
    localparam int EDGE_PIN0_LSB = 0;
    localparam int EDGE_PIN1_LSB = 2;
    localparam int GLOBAL_EN_BIT = 0;

    // Writable masks, where zeros read back as zero, and reset values
    localparam logic [7:0] EDGE_MASK = 8'h0F;
    localparam logic [7:0] PRIM0_MASK = 8'h7F;
    localparam logic [7:0] PRIM_MASK = 8'hFF;
    localparam logic [7:0] GRP_TIMER_MASK = 8'h33;
    localparam logic [7:0] GRP_FULL_MASK = 8'hFF;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [14:0] SRC_RESET = 15'h0000;

    // Primary source positions in the flattened request vectors
    localparam int SRC_PIN0 = 0;
    localparam int SRC_PIN1 = 1;
    localparam int SRC_USB = 2;
    localparam int SRC_MF0 = 5;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Edge select encodings
    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_BOTH = 2'h3
    } ifeb_edge_t;

    // Write channel states, Gray coded
    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_ADDR = 2'h1,
        WR_RESP = 2'h3,
        WR_DATA = 2'h2
    } ifeb_wr_state_t;

    // Event pulses of the directly wired primary sources
    typedef struct packed {
        logic usb;
        logic cp1;
        logic cp0;
        logic sim;
        logic spia;
        logic tb1;
        logic tb0;
    } ifeb_evt_t;

endpackage

// ===== sim/ifeb_peer.sv
// Event source model standing at the far side of the interrupt bank.
// Assumes the bench calls its tasks from one process between edges.
module ifeb_peer
    import ifeb_pkg::*;
(
    input wire logic aclk,
    output logic ext_pin_0,
    output logic ext_pin_1,
    output ifeb_evt_t src_evt,
    output logic [NUM_GRP-1:0][3:0] grp_evt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Sources idle low until the bench asks for an event
    initial begin
        ext_pin_0 = 1'b0;
        ext_pin_1 = 1'b0;
        src_evt = '0;
        grp_evt = '0;
    end

    // One-cycle pulse; a longer pulse would set the flag twice
    task automatic pulse_src(input int b);
        logic [6:0] v;
        v = '0;
        v[b] = 1'b1;
        @(posedge aclk);
        src_evt <= ifeb_evt_t'(v);
        @(posedge aclk);
        src_evt <= '0;
    endtask

    task automatic pulse_grp(input int g, input int b);
        @(posedge aclk);
        grp_evt[g][b] <= 1'b1;
        @(posedge aclk);
        grp_evt[g][b] <= 1'b0;
    endtask

    // Pin level change, held until the next call
    task automatic set_pin(input int p, input logic v);
        @(posedge aclk);
        if (p == 0) ext_pin_0 <= v;
        else ext_pin_1 <= v;
    endtask
endmodule

// ===== sim/interrupt_flag_enable_bank_test.sv
// Self-checking bench of the interrupt flag and enable bank.
// Assumes the bank answers on AXI4-Lite and the peer drives events.
module interrupt_flag_enable_bank_test
    import ifeb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk, aresetn;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic ext_pin_0, ext_pin_1, global_irq_en, irq;
    ifeb_evt_t src_evt;
    logic [NUM_GRP-1:0][3:0] grp_evt;
    logic [NUM_SRC-1:0] cpu_req;
    logic [31:0] fv;
    int n_errors, n_checks;
    // Readable bits of each register after writing all ones
    logic [7:0] wmask [11] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
        8'h33, 8'h33, 8'h33, 8'h33, 8'h33, 8'hFF};
    // Primary sources: register, flag bit, enable bit, request bit
    int ev_reg [7] = '{4, 4, 4, 3, 2, 2, 1};
    int ev_bit [7] = '{5, 6, 4, 7, 4, 5, 6};
    int ev_en [7] = '{1, 2, 0, 3, 0, 1, 3};
    int ev_req [7] = '{12, 13, 11, 10, 3, 4, 2};
    // Group flag position in the primary registers
    int gp_reg [6] = '{2, 2, 3, 3, 3, 4};
    int gp_bit [6] = '{6, 7, 4, 5, 6, 7};

    ifeb_bank #(.ADDR_W(12)) uut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .ext_pin_0(ext_pin_0), .ext_pin_1(ext_pin_1), .src_evt(src_evt),
        .grp_evt(grp_evt), .cpu_req(cpu_req),
        .global_irq_en(global_irq_en), .irq(irq));

    ifeb_peer peer (.aclk(aclk), .ext_pin_0(ext_pin_0),
        .ext_pin_1(ext_pin_1), .src_evt(src_evt), .grp_evt(grp_evt));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic hang(input string what);
        n_errors++;
        $display("unexpected %s wait: expected answer seen none", what);
        test_done();
    endtask

    // Only words past the last register answer with an error
    function automatic logic [1:0] resp_of(input int idx);
        return (idx > int'(IDX_LAST)) ? RESP_SLVERR : RESP_OKAY;
    endfunction

    // Ready is read at the falling edge, where it has settled
    task automatic bus_wr(input int idx, input logic [31:0] d);
        int n;
        logic ad, wd, bd, ah, wh;
        @(posedge aclk);
        awaddr <= 12'(idx * 4);
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ad = 1'b0;
        wd = 1'b0;
        bd = 1'b0;
        n = 0;
        while (!bd && n < 40) begin
            @(negedge aclk);
            ah = !ad && awready;
            wh = !wd && wready;
            bd = ad && wd && bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bd) bready <= 1'b0;
            ad = ad || ah;
            wd = wd || wh;
            n++;
        end
        if (!bd) hang("write");
        check("write response", 32'(rsp), 32'(resp_of(idx)));
    endtask

    task automatic rd_chk(input int idx, input logic [31:0] exp);
        int n;
        logic ad, bd, ah;
        logic [31:0] d;
        @(posedge aclk);
        araddr <= 12'(idx * 4);
        arvalid <= 1'b1;
        rready <= 1'b1;
        ad = 1'b0;
        bd = 1'b0;
        n = 0;
        while (!bd && n < 40) begin
            @(negedge aclk);
            ah = !ad && arready;
            bd = ad && rvalid;
            d = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (bd) rready <= 1'b0;
            ad = ad || ah;
            n++;
        end
        if (!bd) hang("read");
        check($sformatf("register %0d", idx), d, exp);
        check("read response", 32'(rsp), 32'(resp_of(idx)));
    endtask

    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, awprot, arprot, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        n_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, then one word past the map
        for (int i = 0; i <= 13; i++) rd_chk(i, 32'h0);
        bus_wr(13, 32'hFFFF_FFFF);
        $display("test reset done");
        // Unimplemented bits read zero; groups cleared before primaries
        for (int i = 0; i <= 10; i++) bus_wr(i, 32'hFFFF_FFFF);
        for (int i = 0; i <= 10; i++) rd_chk(i, 32'(wmask[i]));
        for (int i = 10; i >= 0; i--) bus_wr(i, 32'h0);
        bus_wr(11, 32'h7FFF);
        $display("test readback done");
        // Every edge mode on both pins, rising then falling
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                bus_wr(0, 32'(m) << (2 * p));
                peer.set_pin(p, 1'b1);
                rd_chk(1, 32'(m[0]) << (4 + p));
                bus_wr(1, 32'h0);
                peer.set_pin(p, 1'b0);
                rd_chk(1, 32'(m[1]) << (4 + p));
                bus_wr(1, 32'h0);
            end
        end
        bus_wr(0, 32'h0);
        bus_wr(11, 32'h7FFF);
        $display("test edges done");
        // Each primary event: flag alone, then enabled, then global off
        for (int b = 0; b < 7; b++) begin
            bus_wr(1, 32'h1);
            check("global enable", 32'(global_irq_en), 32'h1);
            peer.pulse_src(b);
            fv = (32'h1 << ev_bit[b]) | 32'(ev_reg[b] == 1);
            rd_chk(ev_reg[b], fv);
            check("cpu_req", 32'(cpu_req), 32'h0);
            bus_wr(ev_reg[b], fv | (32'h1 << ev_en[b]) | 32'h0);
            check("cpu_req", 32'(cpu_req), 32'h1 << ev_req[b]);
            bus_wr(1, 32'h0);
            check("cpu_req", 32'(cpu_req), 32'h0);
            bus_wr(ev_reg[b], 32'h0);
        end
        bus_wr(11, 32'h7FFF);
        $display("test sources done");
        // Group flag reaches the primary only once enabled in the group
        bus_wr(1, 32'h1);
        for (int g = 0; g < 6; g++) begin
            peer.pulse_grp(g, 1);
            rd_chk(5 + g, 32'h20);
            rd_chk(gp_reg[g], 32'h0);
            bus_wr(5 + g, 32'h22);
            rd_chk(gp_reg[g], 32'h1 << gp_bit[g]);
            bus_wr(5 + g, 32'h0);
            bus_wr(gp_reg[g], 32'h0);
        end
        peer.pulse_grp(5, 3);
        rd_chk(10, 32'h80);
        bus_wr(10, 32'h0);
        bus_wr(11, 32'h7FFF);
        $display("test groups done");
        // Status raised by a pin edge, masked, unmasked, cleared
        bus_wr(0, 32'h1);
        bus_wr(1, 32'h3);
        peer.set_pin(0, 1'b1);
        rd_chk(11, 32'h1);
        check("irq", 32'(irq), 32'h0);
        bus_wr(12, 32'h1);
        check("irq", 32'(irq), 32'h1);
        check("cpu_req", 32'(cpu_req), 32'h1);
        bus_wr(1, 32'h12);
        check("irq", 32'(irq), 32'h0);
        check("cpu_req", 32'(cpu_req), 32'h0);
        bus_wr(1, 32'h0);
        bus_wr(11, 32'h1);
        rd_chk(11, 32'h0);
        rd_chk(12, 32'h1);
        $display("test interrupt done");
        test_done();
    end
endmodule
